// *** ces_pkg.sv ***
/*
 Package for the communication error supervisor: register map, field
 positions, reset values, fault codes and timing constants.
 Assumes a 10 MHz control clock and a 32-bit AXI4-Lite register bus.
*/
package ces_pkg;

  // ****************************************
  // Clock and timing
  // ****************************************
  localparam int unsigned CLK_HZ        = 10_000_000;
  localparam int unsigned TICK_MS       = 100;
  localparam int unsigned TICK_CYCLES   = CLK_HZ / 1000 * TICK_MS;
  localparam int unsigned HOUR_S        = 3600;
  localparam int unsigned COMMIT_TICKS  = HOUR_S * 1000 / TICK_MS;

  // ****************************************
  // Register byte offsets
  // ****************************************
  localparam logic [7:0] ADDR_CTRL      = 8'h00;
  localparam logic [7:0] ADDR_WAIT      = 8'h04;
  localparam logic [7:0] ADDR_COUNT     = 8'h08;
  localparam logic [7:0] ADDR_MODE      = 8'h0C;
  localparam logic [7:0] ADDR_FALLBACK  = 8'h10;
  localparam logic [7:0] ADDR_STATUS    = 8'h14;
  localparam logic [7:0] ADDR_FAULT     = 8'h18;
  localparam logic [7:0] ADDR_SAVED     = 8'h1C;

  // ****************************************
  // Field widths, limits and reset values
  // ****************************************
  localparam int unsigned WAIT_W        = 14;
  localparam logic [13:0] WAIT_MAX      = 14'h270E;
  localparam logic [13:0] WAIT_RST      = 14'h0000;
  localparam logic [1:0]  MODE_RST      = 2'h0;
  localparam int unsigned FREQ_W        = 16;
  localparam logic [15:0] FREQ_MAX      = 16'h024E;
  localparam logic [15:0] FREQ_KEEP     = 16'h270F;
  localparam logic [15:0] FREQ_RST      = 16'h270F;
  localparam int unsigned CNT_W         = 16;

  // Control register bits
  localparam int unsigned CTRL_NET      = 0;
  localparam int unsigned CTRL_RESET    = 1;

  // Fault codes
  localparam logic [7:0] FAULT_NONE     = 8'h00;
  localparam logic [7:0] FAULT_LINE     = 8'hA1;
  localparam logic [7:0] FAULT_OPTION   = 8'hF1;

  // AXI responses
  localparam logic [1:0] RESP_OKAY      = 2'h0;
  localparam logic [1:0] RESP_SLVERR    = 2'h2;

  typedef enum logic [1:0] {
    STOP_COAST,
    STOP_DECEL,
    STOP_DECEL_RESUME,
    STOP_CONTINUE
  } ces_mode_t;

endpackage

// *** ces_cfg_if.sv ***
/*
 Interface carrying written settings and requests from the register slave
 to the supervisor core, and core status back.
 Assumes both ends share aclk.
*/
`timescale 1ns/1ps
interface ces_cfg_if;
  import ces_pkg::*;
  logic [WAIT_W-1:0] wait_time;
  logic [1:0]        stop_mode;
  logic [FREQ_W-1:0] fallback;
  logic              net_mode;
  logic              reset_req;
  logic              count_clear;
  logic [CNT_W-1:0]  count;
  logic [CNT_W-1:0]  count_saved;
  logic [7:0]        status;
  logic [7:0]        fault_code;
  logic [7:0]        history;
  logic              reset_refused;

  modport regs (output wait_time, stop_mode, fallback, net_mode, reset_req, count_clear,
                input count, count_saved, status, fault_code, history, reset_refused);
  modport core (input wait_time, stop_mode, fallback, net_mode, reset_req, count_clear,
                output count, count_saved, status, fault_code, history, reset_refused);
endinterface

// *** ces_tick.sv ***
/*
 Divider producing a one-cycle enable every 0.1 s.
 Assumes aclk at the package clock rate.
*/
`timescale 1ns/1ps
module ces_tick
  import ces_pkg::*;
#(
  parameter int unsigned CYCLES = TICK_CYCLES
) (
  input  wire logic aclk,    // Control clock
  input  wire logic aresetn, // Sync reset, low
  output logic      tick     // One-cycle pulse
);
  logic [23:0] cnt_q;
  wire         wrap = (cnt_q == 24'(CYCLES - 1));

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_q <= 24'h00_0000;
      tick  <= 1'b0;
    end else begin
      cnt_q <= wrap ? 24'h00_0000 : cnt_q + 24'h00_0001;
      tick  <= wrap;
    end
  end
endmodule

// *** ces_top.sv ***
/*
 Communication error supervisor: qualifies line errors against a waiting
 time, counts occurrences, selects the stop reaction and drives fault
 output, indication and history. Registers over AXI4-Lite.
 Assumes line_error and option_error are pins, net_mode from software,
 and a drive that reports motor standstill on drive_stopped.
*/
`timescale 1ns/1ps
module ces_top
  import ces_pkg::*;
#(
  parameter int unsigned TICK_CYC   = TICK_CYCLES,
  parameter int unsigned COMMIT_TK  = COMMIT_TICKS
) (
  input  wire logic        aclk,            // Control clock
  input  wire logic        aresetn,         // Sync reset, low
  input  wire logic [7:0]  s_axi_awaddr,    // Write address
  input  wire logic        s_axi_awvalid,   // Write address valid
  output logic             s_axi_awready,   // Write address ready
  input  wire logic [31:0] s_axi_wdata,     // Write data
  input  wire logic [3:0]  s_axi_wstrb,     // Byte enables
  input  wire logic        s_axi_wvalid,    // Write data valid
  output logic             s_axi_wready,    // Write data ready
  output logic [1:0]       s_axi_bresp,     // Write response
  output logic             s_axi_bvalid,    // Write response valid
  input  wire logic        s_axi_bready,    // Write response ready
  input  wire logic [7:0]  s_axi_araddr,    // Read address
  input  wire logic        s_axi_arvalid,   // Read address valid
  output logic             s_axi_arready,   // Read address ready
  output logic [31:0]      s_axi_rdata,     // Read data
  output logic [1:0]       s_axi_rresp,     // Read response
  output logic             s_axi_rvalid,    // Read data valid
  input  wire logic        s_axi_rready,    // Read data ready
  input  wire logic        line_error,      // Line fault pin
  input  wire logic        option_error,    // Option unit fault pin
  input  wire logic        drive_stopped,   // Motor at standstill
  input  wire logic        run_cmd,         // Network run command
  input  wire logic [15:0] freq_cmd,        // Network frequency command
  output logic             run_out,         // Run to the drive
  output logic             coast_out,       // Free-run stop
  output logic             decel_out,       // Ramp stop, ordinary times
  output logic [15:0]      freq_out,        // Frequency to the drive
  output logic             fault_alarm_signal, // Alarm output
  output logic             line_error_fault,   // Line fault shown
  output logic             history_write       // Pulse: history stored
);

  ces_cfg_if cfg ();
  logic tick;

  ces_tick #(.CYCLES(TICK_CYC)) u_tick (
    .aclk    (aclk),
    .aresetn (aresetn),
    .tick    (tick)
  );

  // ****************************************
  // Input synchronisers
  // ****************************************
  logic [2:0] line_s_q;
  logic [2:0] opt_s_q;
  logic       line_q;
  logic       opt_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      line_s_q <= 3'h0;
      opt_s_q  <= 3'h0;
      line_q   <= 1'b0;
      opt_q    <= 1'b0;
    end else begin
      line_s_q <= {line_s_q[1:0], line_error};
      opt_s_q  <= {opt_s_q[1:0], option_error};
      if (line_s_q[1] == line_s_q[2]) line_q <= line_s_q[2];
      if (opt_s_q[1] == opt_s_q[2])   opt_q  <= opt_s_q[2];
    end
  end

  logic line_d1_q;
  wire  line_rise = line_q && !line_d1_q;

  // ****************************************
  // Register bus
  // ****************************************
  logic [7:0]  awaddr_q;
  logic        aw_have_q;
  logic [31:0] wdata_q;
  logic [3:0]  wstrb_q;
  logic        w_have_q;
  logic [WAIT_W-1:0] wait_q;
  logic [1:0]        mode_q;
  logic [FREQ_W-1:0] fb_q;
  logic              net_q;

  wire do_wr    = aw_have_q && w_have_q && !s_axi_bvalid;
  wire wr_ctrl  = do_wr && awaddr_q == ADDR_CTRL;
  wire wr_wait  = do_wr && awaddr_q == ADDR_WAIT;
  wire wr_count = do_wr && awaddr_q == ADDR_COUNT;
  wire wr_mode  = do_wr && awaddr_q == ADDR_MODE;
  wire wr_fb    = do_wr && awaddr_q == ADDR_FALLBACK;
  wire wr_hit   = wr_ctrl | wr_wait | wr_count | wr_mode | wr_fb;
  wire wr_full  = &wstrb_q;
  wire wait_ok  = wdata_q[WAIT_W-1:0] <= WAIT_MAX;
  wire fb_ok    = wdata_q[FREQ_W-1:0] <= FREQ_MAX || wdata_q[FREQ_W-1:0] == FREQ_KEEP;
  wire mode_ok  = wdata_q[31:2] == 30'h0000_0000;
  wire clr_hit  = wr_count && wr_full && wdata_q == 32'h0000_0000;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      aw_have_q     <= 1'b0;
      w_have_q      <= 1'b0;
      awaddr_q      <= 8'h00;
      wdata_q       <= 32'h0000_0000;
      wstrb_q       <= 4'h0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awaddr_q      <= s_axi_awaddr;
        aw_have_q     <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wdata_q      <= s_axi_wdata;
        wstrb_q      <= s_axi_wstrb;
        w_have_q     <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (do_wr) begin
        aw_have_q    <= 1'b0;
        w_have_q     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // Settings; out-of-range field values are ignored and the old setting kept; wait and fallback do not check bits above their fields
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wait_q <= WAIT_RST;
      mode_q <= MODE_RST;
      fb_q   <= FREQ_RST;
      net_q  <= 1'b0;
    end else begin
      if (wr_wait && wr_full && wait_ok) wait_q <= wdata_q[WAIT_W-1:0];
      if (wr_mode && wr_full && mode_ok) mode_q <= wdata_q[1:0];
      if (wr_fb && wr_full && fb_ok) fb_q <= wdata_q[FREQ_W-1:0];
      if (wr_ctrl && wr_full) net_q <= wdata_q[CTRL_NET];
    end
  end

  assign cfg.wait_time   = wait_q;
  assign cfg.stop_mode   = mode_q;
  assign cfg.fallback    = fb_q;
  assign cfg.net_mode    = net_q;
  assign cfg.reset_req   = wr_ctrl && wr_full && wdata_q[CTRL_RESET];
  assign cfg.count_clear = clr_hit;

  wire [31:0] rd_mux =
    (s_axi_araddr == ADDR_CTRL)     ? {31'h0, net_q} :
    (s_axi_araddr == ADDR_WAIT)     ? {18'h0, wait_q} :
    (s_axi_araddr == ADDR_COUNT)    ? {16'h0, cfg.count} :
    (s_axi_araddr == ADDR_MODE)     ? {30'h0, mode_q} :
    (s_axi_araddr == ADDR_FALLBACK) ? {16'h0, fb_q} :
    (s_axi_araddr == ADDR_STATUS)   ? {24'h0, cfg.status} :
    (s_axi_araddr == ADDR_FAULT)    ? {16'h0, cfg.history, cfg.fault_code} :
    (s_axi_araddr == ADDR_SAVED)    ? {16'h0, cfg.count_saved} : 32'h0000_0000;
  wire rd_hit = s_axi_araddr <= ADDR_SAVED && s_axi_araddr[1:0] == 2'h0;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= rd_mux;
      s_axi_rresp   <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // ****************************************
  // Waiting timer and error counter
  // ****************************************
  logic [WAIT_W-1:0] wcnt_q;
  logic              qual_q;
  logic [CNT_W-1:0]  cnt_q;
  // Power-up contents of the nonvolatile image; aresetn leaves them alone
  logic [CNT_W-1:0]  saved_q = CNT_W'(0);
  logic [15:0]       hour_q  = 16'h0000;
  logic              boot_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      line_d1_q <= 1'b0;
      wcnt_q    <= WAIT_RST;
      qual_q    <= 1'b0;
    end else begin
      line_d1_q <= line_q;
      if (!line_q) begin
        wcnt_q <= WAIT_RST;
        qual_q <= 1'b0;
      end else if (line_rise) begin
        wcnt_q <= WAIT_RST;
        qual_q <= (wait_q == WAIT_RST);
      end else if (tick && !qual_q) begin
        wcnt_q <= wcnt_q + 14'h0001;
        if (wcnt_q + 14'h0001 > wait_q) qual_q <= 1'b1;
      end
    end
  end

  // Saved image survives aresetn: it models the hourly nonvolatile copy
  always_ff @(posedge aclk) begin
    hour_q <= (tick && hour_q == 16'(COMMIT_TK - 1)) ? 16'h0000 :
              tick ? hour_q + 16'h0001 : hour_q;
    if (tick && hour_q == 16'(COMMIT_TK - 1)) saved_q <= cnt_q;
    if (!aresetn) begin
      cnt_q  <= CNT_W'(0);
      boot_q <= 1'b1;
    end else if (boot_q) begin
      cnt_q  <= saved_q;
      boot_q <= 1'b0;
    end else if (line_rise) begin
      cnt_q  <= cnt_q + 16'h0001;
    end else if (clr_hit) begin
      cnt_q  <= CNT_W'(0);
    end
  end

  assign cfg.count       = cnt_q;
  assign cfg.count_saved = saved_q;

  // ****************************************
  // Stop reaction
  // ****************************************
  ces_mode_t mode;
  assign mode = ces_mode_t'(mode_q);

  logic        latched_q;  // Stopped with fault, until reset
  logic        fault_pend_q;
  logic        opt_fault_q;
  logic        pause_q;    // Mode 2 stop, restart later
  logic [15:0] prev_freq_q;
  logic        prev_run_q;
  logic [7:0]  code_q;
  logic [7:0]  hist_q;
  logic        refused_q;

  wire net_line  = qual_q && net_q;
  wire opt_evt   = opt_q && !opt_fault_q && !latched_q && !fault_pend_q;
  wire line_evt  = net_line && !latched_q && !fault_pend_q && !pause_q;
  wire coast_now = mode == STOP_COAST || (opt_evt && mode == STOP_CONTINUE);
  wire keep_on   = mode == STOP_CONTINUE;
  wire rst_ok    = cfg.reset_req && !line_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      latched_q    <= 1'b0;
      fault_pend_q <= 1'b0;
      opt_fault_q  <= 1'b0;
      pause_q      <= 1'b0;
      coast_out    <= 1'b0;
      decel_out    <= 1'b0;
      fault_alarm_signal <= 1'b0;
      line_error_fault   <= 1'b0;
      history_write      <= 1'b0;
      code_q       <= FAULT_NONE;
      hist_q       <= FAULT_NONE;
      refused_q    <= 1'b0;
    end else begin
      history_write <= 1'b0;
      refused_q     <= cfg.reset_req ? line_q : refused_q;
      if (rst_ok) begin
        latched_q    <= 1'b0;
        fault_pend_q <= 1'b0;
        opt_fault_q  <= 1'b0;
        coast_out    <= 1'b0;
        decel_out    <= 1'b0;
        fault_alarm_signal <= 1'b0;
        line_error_fault   <= 1'b0;
        code_q       <= FAULT_NONE;
      end else if (opt_evt) begin
        opt_fault_q <= 1'b1;
        pause_q     <= 1'b0;
        code_q      <= FAULT_OPTION;
        if (coast_now) begin
          coast_out <= 1'b1;
          latched_q <= 1'b1;
          fault_alarm_signal <= 1'b1;
          history_write <= 1'b1;
          hist_q    <= FAULT_OPTION;
        end else begin
          decel_out    <= 1'b1;
          fault_pend_q <= 1'b1;
        end
      end else if (line_evt) begin
        code_q <= FAULT_LINE;
        line_error_fault <= !keep_on && mode != STOP_DECEL_RESUME;
        unique case (mode)
          STOP_COAST: begin
            coast_out <= 1'b1;
            latched_q <= 1'b1;
            fault_alarm_signal <= 1'b1;
            history_write <= 1'b1;
            hist_q    <= FAULT_LINE;
          end
          STOP_DECEL: begin
            decel_out    <= 1'b1;
            fault_pend_q <= 1'b1;
            line_error_fault <= 1'b0;
          end
          STOP_DECEL_RESUME: begin
            decel_out <= 1'b1;
            pause_q   <= 1'b1;
          end
          STOP_CONTINUE: begin
          end
        endcase
      end else if (fault_pend_q && drive_stopped) begin
        fault_pend_q <= 1'b0;
        latched_q    <= 1'b1;
        fault_alarm_signal <= 1'b1;
        line_error_fault   <= !opt_fault_q;
        history_write <= 1'b1;
        hist_q       <= code_q;
      end else if (pause_q && !line_q) begin
        pause_q   <= 1'b0;
        decel_out <= 1'b0;
        code_q    <= FAULT_NONE;
      end else if (!latched_q && !fault_pend_q && !pause_q && !opt_fault_q && !net_line) begin
        code_q <= FAULT_NONE;
      end
    end
  end

  assign cfg.status = {3'h0, refused_q, pause_q, fault_pend_q, latched_q,
                       fault_alarm_signal};
  assign cfg.fault_code    = code_q;
  assign cfg.history       = hist_q;
  assign cfg.reset_refused = refused_q;

  // ****************************************
  // Run and frequency to the drive
  // ****************************************
  // Event terms drop run in the same cycle as the stop outputs rise
  wire stopping = latched_q || fault_pend_q || pause_q || opt_fault_q ||
                  opt_evt || (line_evt && !keep_on);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prev_freq_q <= 16'h0000;
      prev_run_q  <= 1'b0;
      run_out     <= 1'b0;
      freq_out    <= 16'h0000;
    end else begin
      if (!line_q && !stopping) begin
        prev_freq_q <= freq_cmd;
        prev_run_q  <= run_cmd;
      end
      run_out <= stopping ? 1'b0 : (line_q ? prev_run_q : run_cmd);
      if (net_line && keep_on)
        freq_out <= (fb_q == FREQ_KEEP) ? prev_freq_q : fb_q;
      else
        freq_out <= line_q ? prev_freq_q : freq_cmd;
    end
  end

endmodule

// *** ces_properties.sv ***
/* Port checker for ces_top.
   Assumes a bind onto ces_top, port names matching. */
`timescale 1ns/1ps
module ces_properties
  import ces_pkg::*;
(
  input wire logic        aclk,               // Clock
  input wire logic        aresetn,            // Reset, low
  input wire logic        s_axi_arvalid,      // AR valid
  input wire logic        s_axi_arready,      // AR ready
  input wire logic [31:0] s_axi_rdata,        // R data
  input wire logic        s_axi_rvalid,       // R valid
  input wire logic        s_axi_rready,       // R ready
  input wire logic [1:0]  s_axi_bresp,        // B resp
  input wire logic        s_axi_bvalid,       // B valid
  input wire logic        s_axi_bready,       // B ready
  input wire logic        line_error,         // Line pin
  input wire logic        option_error,       // Option pin
  input wire logic        drive_stopped,      // Standstill
  input wire logic        run_out,            // Run
  input wire logic        coast_out,          // Coast
  input wire logic        decel_out,          // Ramp stop
  input wire logic        fault_alarm_signal, // Alarm
  input wire logic        history_write       // History pulse
);
  // ****************************************
  // Cycles since both error pins went quiet
  // ****************************************
  logic [3:0] quiet_q;
  logic [3:0] quiet_d;
  assign quiet_d = (line_error || option_error) ? 4'h0 :
                   (quiet_q == 4'hF) ? quiet_q : quiet_q + 4'h1;
  always_ff @(posedge aclk) begin
    quiet_q <= aresetn ? quiet_d : 4'hF;
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_rvalid_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  a_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while busy");
  a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  a_hist_pulse: assert property (history_write |=> !history_write)
    else $error("history pulse too long");
  a_alarm_history: assert property ($rose(fault_alarm_signal) |-> ##[0:1] history_write)
    else $error("alarm without history record");
  a_stop_cause: assert property ($rose(coast_out) || $rose(decel_out) |->
    quiet_q < 4'h6)
    else $error("stop with no error present");
  a_coast_no_run: assert property (coast_out |-> !run_out)
    else $error("running while coasting");
  a_alarm_at_stop: assert property ($rose(fault_alarm_signal) && decel_out |->
    $past(drive_stopped))
    else $error("alarm before standstill");
endmodule

bind ces_top ces_properties u_props (.*);

// *** ces_master_model.sv ***
/* Network master and drive stand-in: commands, line pin, standstill.
   Assumes the bench raises cut to break the line. */
`timescale 1ns/1ps
module ces_master_model
  import ces_pkg::*;
#(
  parameter logic [15:0] CMD_FREQ = 16'h0064
) (
  input  wire logic        aclk,          // Clock
  input  wire logic        aresetn,       // Reset, low
  input  wire logic        cut,           // Break the line
  input  wire logic        stop_req,      // Coast or ramp seen
  output logic             line_error,    // Line pin
  output logic             run_cmd,       // Run command
  output logic [15:0]      freq_cmd,      // Frequency command
  output logic             drive_stopped  // Standstill
);
  logic [4:0] spin_q;
  initial begin
    line_error = 1'b0;
    run_cmd = 1'b0;
    freq_cmd = 16'h0;
    spin_q = 5'd20;
  end
  // Motor takes 20 cycles to halt, so stop-time faults show late
  always @(posedge aclk) begin
    line_error <= cut;
    run_cmd <= aresetn;
    freq_cmd <= CMD_FREQ;
    spin_q <= !stop_req ? 5'd20 : (spin_q == 5'd0) ? spin_q : spin_q - 5'd1;
  end
  assign drive_stopped = (stop_req === 1'b1) && (spin_q == 5'd0);
endmodule

// *** comm_error_supervisor_tb_top.sv ***
/* Bench for ces_top: AXI4-Lite tasks and error scenarios.
   Assumes tick of 10 cycles, commit every 4 ticks. */
`timescale 1ns/1ps
module comm_error_supervisor_tb_top;
  import ces_pkg::*;
  logic        aclk = 0, aresetn = 0, cut = 0, option_error = 0;
  logic [7:0]  s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, rd_q;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic        s_axi_arvalid = 0, s_axi_rready = 0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rresp_q, bresp_q;
  logic        line_error, drive_stopped, run_cmd, run_out, coast_out, decel_out;
  logic        fault_alarm_signal, line_error_fault, history_write;
  logic [15:0] freq_cmd, freq_out;
  int          err_total = 0, tests_run = 0, cyc = 0;

  always #50 aclk = ~aclk;
  ces_top #(.TICK_CYC(10), .COMMIT_TK(4)) dut (.*);
  ces_master_model u_master (.aclk(aclk), .aresetn(aresetn), .cut(cut),
    .stop_req(coast_out | decel_out), .line_error(line_error), .run_cmd(run_cmd),
    .freq_cmd(freq_cmd), .drive_stopped(drive_stopped));

  // ****************************************
  // Bus and check tasks
  // ****************************************
  task automatic chk(input bit ok);
    tests_run++;
    if (!ok) begin
      err_total++;
      $display("BAD %0t check %0d", $time, tests_run);
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge aclk);
  endtask
  // Trailing edge keeps the next call off the release step
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    bresp_q = s_axi_bresp;
    s_axi_bready <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic rd(input logic [7:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    rd_q = s_axi_rdata;
    rresp_q = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    rd(a);
    chk(rd_q === e);
  endtask
  task automatic print_verdict;
    if (err_total == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  always @(posedge aclk) begin
    cyc++;
    if (cyc == 4000) begin
      err_total++;
      print_verdict();
    end
  end

  // ****************************************
  // Scenarios
  // ****************************************
  initial begin
    idle(20);
    aresetn <= 1'b1;
    idle(1);
    rdc(ADDR_MODE, 32'h0);
    rdc(ADDR_WAIT, 32'h0);
    rdc(ADDR_FALLBACK, 32'h270F);
    rd(8'h40);
    chk(rresp_q === RESP_SLVERR);
    wr(ADDR_CTRL, 32'h1);
    chk(bresp_q === RESP_OKAY);
    wr(8'h40, 32'h1);
    chk(bresp_q === RESP_SLVERR);
    wr(ADDR_WAIT, 32'h270F);
    rdc(ADDR_WAIT, 32'h0);
    wr(ADDR_WAIT, 32'h270E);
    rdc(ADDR_WAIT, 32'h270E);
    wr(ADDR_WAIT, 32'h3);
    wr(ADDR_FALLBACK, 32'h32);
    cut <= 1'b1;
    idle(15);
    cut <= 1'b0;
    idle(60);
    chk(fault_alarm_signal === 0 && run_out === 1 && coast_out === 0 && decel_out === 0);
    rdc(ADDR_COUNT, 32'h1);
    wr(ADDR_MODE, 32'h3);
    cut <= 1'b1;
    idle(100);
    chk(run_out === 1 && freq_out === 16'h0032 && fault_alarm_signal === 0);
    cut <= 1'b0;
    idle(20);
    chk(freq_out === 16'h0064);
    wr(ADDR_MODE, 32'h2);
    cut <= 1'b1;
    idle(100);
    chk(decel_out === 1 && fault_alarm_signal === 0);
    wr(ADDR_CTRL, 32'h3);
    rd(ADDR_STATUS);
    chk(rd_q[4] === 1'b1);
    rdc(ADDR_FAULT, {16'h0000, FAULT_NONE, FAULT_LINE});
    cut <= 1'b0;
    idle(20);
    chk(run_out === 1 && decel_out === 0 && freq_out === 16'h0064);
    rdc(ADDR_FAULT, 32'h0000_0000);
    rdc(ADDR_COUNT, 32'h3);
    wr(ADDR_COUNT, 32'h5);
    rdc(ADDR_COUNT, 32'h3);
    wr(ADDR_COUNT, 32'h0);
    rdc(ADDR_COUNT, 32'h0);
    wr(ADDR_CTRL, 32'h0);
    wr(ADDR_MODE, 32'h0);
    cut <= 1'b1;
    idle(100);
    chk(run_out === 1 && coast_out === 0 && fault_alarm_signal === 0);
    cut <= 1'b0;
    idle(20);
    wr(ADDR_CTRL, 32'h1);
    cut <= 1'b1;
    idle(100);
    chk(coast_out === 1 && fault_alarm_signal === 1 && line_error_fault === 1);
    cut <= 1'b0;
    idle(20);
    chk(coast_out === 1 && fault_alarm_signal === 1 && line_error_fault === 1);
    rd(ADDR_FAULT);
    chk(rd_q === {16'h0000, FAULT_LINE, FAULT_LINE});
    idle(80);
    aresetn <= 1'b0;
    idle(20);
    aresetn <= 1'b1;
    idle(3);
    rdc(ADDR_COUNT, 32'h2);
    wr(ADDR_CTRL, 32'h1);
    wr(ADDR_MODE, 32'h1);
    wr(ADDR_MODE, 32'h7);
    rdc(ADDR_MODE, 32'h1);
    option_error <= 1'b1;
    idle(8);
    chk(decel_out === 1 && fault_alarm_signal === 0);
    idle(40);
    chk(fault_alarm_signal === 1);
    rd(ADDR_FAULT);
    chk(rd_q === {16'h0000, FAULT_OPTION, FAULT_OPTION});
    option_error <= 1'b0;
    idle(10);
    wr(ADDR_CTRL, 32'h3);
    chk(fault_alarm_signal === 0 && decel_out === 0);
    cut <= 1'b1;
    idle(100);
    chk(decel_out === 1 && fault_alarm_signal === 1 && line_error_fault === 1);
    cut <= 1'b0;
    idle(20);
    chk(decel_out === 1 && fault_alarm_signal === 1 && run_out === 0);
    rdc(ADDR_FAULT, {16'h0000, FAULT_LINE, FAULT_LINE});
    print_verdict();
  end
endmodule
